// File: hw/clk_switch_pkg.sv
// Package with register map, field positions and reset values of the switch.
package clk_switch_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FREQ_W = 8;
  localparam int CNT_W = 10;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] FREQ_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] STOP_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] STAT_OFF = 8'h0C;
  localparam int SEL_BIT = 4;
  localparam int STATUS_BIT = 5;
  localparam int FIH_LSB = 0;
  localparam int FMX_LSB = 8;
  localparam int SYS_STOP_BIT = 0;
  localparam int OSC_STOP_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam int CNT_LSB = 8;
  localparam logic SEL_RST = 1'b0;
  localparam logic SYS_STOP_RST = 1'b1;
  localparam logic OSC_STOP_RST = 1'b0;
  localparam logic [FREQ_W-1:0] FIH_RST = 8'h08;
  localparam logic [FREQ_W-1:0] FMX_RST = 8'h0A;
  localparam logic [CNT_W-1:0] FIXED_CYCLES = 10'h002;
  localparam logic [CNT_W-1:0] ONE_CYCLE = 10'h001;
  typedef enum logic [1:0] {SW_IDLE, SW_CALC, SW_WAIT} sw_state_t;
endpackage

// File: hw/reset_release.sv
// Two-stage release of the asynchronous active-low reset.
`timescale 1ns/1ps
module reset_release (
  input wire logic clk,
  input wire logic rst_b,
  output logic rst_sync_b
);
  logic meta_ff;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      meta_ff <= 1'b1;
      rst_sync_b <= meta_ff;
    end
  end
endmodule

// File: hw/ceil_divider.sv
// Serial restoring divider that returns the quotient rounded up.
`timescale 1ns/1ps
module ceil_divider (
  input wire logic clk,
  input wire logic rst_sync_b,
  input wire logic start,
  input wire logic [9:0] num,
  input wire logic [7:0] den,
  output logic done,
  output logic [9:0] quo
);
  logic [9:0] q_ff;
  logic [9:0] rem_ff;
  logic [3:0] step_ff;
  logic busy_ff;
  logic [7:0] den_ff;
  logic [9:0] trial;

  assign trial = {rem_ff[8:0], q_ff[9]};
  assign quo = q_ff + {9'h000, rem_ff != 10'h000};

  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      q_ff <= 10'h000;
      rem_ff <= 10'h000;
      step_ff <= 4'h0;
      busy_ff <= 1'b0;
      den_ff <= 8'h01;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        q_ff <= num;
        rem_ff <= 10'h000;
        step_ff <= 4'h0;
        busy_ff <= 1'b1;
        // A zero frequency would divide by zero, so it counts as one.
        den_ff <= (den == 8'h00) ? 8'h01 : den;
      end
      else if (busy_ff)
      begin
        if (trial >= {2'b00, den_ff})
        begin
          rem_ff <= trial - {2'b00, den_ff};
          q_ff <= {q_ff[8:0], 1'b1};
        end
        else
        begin
          rem_ff <= trial;
          q_ff <= {q_ff[8:0], 1'b0};
        end
        step_ff <= step_ff + 4'h1;
        if (step_ff == 4'h9)
        begin
          busy_ff <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// File: hw/main_clock_switchover.sv
// Main system clock selector with bounded, old-clock-counted switchover.
//
// Summary of operation
// - Select bit 4 picks internal or system clock.
// - Keep old clock several cycles after rewrite.
// - Status bit 5 shows the active source.
// - Peripheral clock follows the CPU clock source.
// - Latency bounded by fixed or ratio formulas.
// - Latency counted in old clock cycles.
// - Fractional cycle counts round up.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module main_clock_switchover (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [clk_switch_pkg::ADDR_W-1:0] addr,
  input wire logic [clk_switch_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [clk_switch_pkg::DATA_W-1:0] rd_data,
  input wire logic int_osc_tick,
  input wire logic sys_clk_tick,
  output logic main_clk_sel,
  output logic periph_clk_sel,
  output logic system_clock_stop_ctrl,
  output logic internal_osc_stop_ctrl
);
  import clk_switch_pkg::*;

  logic rst_sync_b;
  logic main_clock_select_bit_ff;
  logic main_clock_status_bit_ff;
  logic periph_sel_ff;
  logic sys_stop_ff;
  logic osc_stop_ff;
  logic [FREQ_W-1:0] fih_ff;
  logic [FREQ_W-1:0] fmx_ff;
  logic [DATA_W-1:0] rd_data_ff;
  sw_state_t state_ff;
  logic target_ff;
  logic [CNT_W-1:0] limit_ff;
  logic [CNT_W-1:0] count_ff;
  logic div_start_ff;
  logic [9:0] div_num_ff;
  logic [7:0] div_den_ff;
  logic div_done;
  logic [9:0] div_quo;
  logic old_tick;
  logic mx_fast;
  logic [DATA_W-1:0] nxt_rd_data;

  // True when a strobe addresses the given register.
  function automatic logic reg_hit(
    input logic en,
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] off
  );
    return en && (a == off);
  endfunction

  // True on the old-clock tick that completes the counted wait.
  function automatic logic wait_over(
    input sw_state_t st,
    input logic tick,
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] lim
  );
    return (st == SW_WAIT) && tick && (cnt + ONE_CYCLE >= lim);
  endfunction

  // Every register below leaves reset two edges after rst_b rises.
  reset_release u_reset (
    .clk(clk),
    .rst_b(rst_b),
    .rst_sync_b(rst_sync_b)
  );

  // Ratio bounds are worked out serially before the wait begins.
  ceil_divider u_div (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .start(div_start_ff),
    .num(div_num_ff),
    .den(div_den_ff),
    .done(div_done),
    .quo(div_quo)
  );

  // Equal frequencies take the fixed bound only when switching to the system clock.
  assign mx_fast = (fmx_ff >= fih_ff);
  // Ticks of the source in use before the change pace the wait.
  assign old_tick = main_clock_status_bit_ff ? sys_clk_tick
                                             : int_osc_tick;

  // Select bit; a rewrite only requests a change.
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      main_clock_select_bit_ff <= SEL_RST;
    end
    else if (reg_hit(wr_en, addr, CTRL_OFF))
    begin
      main_clock_select_bit_ff <= wr_data[SEL_BIT];
    end
  end

  // Frequency settings that feed the latency bound.
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      fih_ff <= FIH_RST;
      fmx_ff <= FMX_RST;
    end
    else if (reg_hit(wr_en, addr, FREQ_OFF))
    begin
      fih_ff <= wr_data[FIH_LSB +: FREQ_W];
      fmx_ff <= wr_data[FMX_LSB +: FREQ_W];
    end
  end

  // Stop controls of the two sources.
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      sys_stop_ff <= SYS_STOP_RST;
      osc_stop_ff <= OSC_STOP_RST;
    end
    else if (reg_hit(wr_en, addr, STOP_OFF))
    begin
      // A write never stops the running source under the CPU; a switch to an already stopped source is not blocked.
      if (!(wr_data[SYS_STOP_BIT] && main_clock_status_bit_ff))
      begin
        sys_stop_ff <= wr_data[SYS_STOP_BIT];
      end
      if (!(wr_data[OSC_STOP_BIT] && !main_clock_status_bit_ff))
      begin
        osc_stop_ff <= wr_data[OSC_STOP_BIT];
      end
    end
  end

  // Switchover sequencer: work out the bound, then count old ticks.
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state_ff <= SW_IDLE;
      target_ff <= SEL_RST;
      // The bound register reads as the fixed count after reset.
      limit_ff <= FIXED_CYCLES;
      count_ff <= '0;
      div_start_ff <= 1'b0;
      div_num_ff <= 10'h000;
      div_den_ff <= 8'h01;
    end
    else
    begin
      div_start_ff <= 1'b0;
      unique case (state_ff)
        // A select change during a wait is taken up back in idle.
        SW_IDLE:
        begin
          count_ff <= '0;
          // A rewrite does not move the mux at once.
          if (main_clock_select_bit_ff != main_clock_status_bit_ff)
          begin
            target_ff <= main_clock_select_bit_ff;
            if (main_clock_select_bit_ff == mx_fast)
            begin
              limit_ff <= FIXED_CYCLES;
              state_ff <= SW_WAIT;
            end
            else if (main_clock_select_bit_ff)
            begin
              div_num_ff <= {2'b00, fih_ff};
              div_den_ff <= fmx_ff;
              div_start_ff <= 1'b1;
              state_ff <= SW_CALC;
            end
            else
            begin
              // Twice the system frequency over the internal one.
              div_num_ff <= {1'b0, fmx_ff, 1'b0};
              div_den_ff <= fih_ff;
              div_start_ff <= 1'b1;
              state_ff <= SW_CALC;
            end
          end
        end
        SW_CALC:
        begin
          // The divider answers about a dozen cycles after its start.
          if (div_done)
          begin
            // The divider already rounds a remainder up.
            if (target_ff)
            begin
              limit_ff <= div_quo + ONE_CYCLE;
            end
            else
            begin
              limit_ff <= div_quo;
            end
            state_ff <= SW_WAIT;
          end
        end
        SW_WAIT:
        begin
          // Only ticks of the old source advance the count.
          if (old_tick)
          begin
            count_ff <= count_ff + ONE_CYCLE;
          end
          if (wait_over(state_ff, old_tick, count_ff, limit_ff))
          begin
            state_ff <= SW_IDLE;
          end
        end
        default:
        begin
          // An unused state code falls back to idle.
          state_ff <= SW_IDLE;
        end
      endcase
    end
  end

  // The mux select and the status move together at the end of the wait.
  // Peripheral and CPU selects can therefore never disagree.
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      main_clock_status_bit_ff <= SEL_RST;
      periph_sel_ff <= SEL_RST;
    end
    else if (wait_over(state_ff, old_tick, count_ff, limit_ff))
    begin
      main_clock_status_bit_ff <= target_ff;
      periph_sel_ff <= target_ff;
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb
  begin
    nxt_rd_data = '0;
    unique case (addr)
      CTRL_OFF:
      begin
        nxt_rd_data[SEL_BIT] = main_clock_select_bit_ff;
        nxt_rd_data[STATUS_BIT] = main_clock_status_bit_ff;
      end
      FREQ_OFF:
      begin
        nxt_rd_data[FIH_LSB +: FREQ_W] = fih_ff;
        nxt_rd_data[FMX_LSB +: FREQ_W] = fmx_ff;
      end
      STOP_OFF:
      begin
        nxt_rd_data[SYS_STOP_BIT] = sys_stop_ff;
        nxt_rd_data[OSC_STOP_BIT] = osc_stop_ff;
      end
      STAT_OFF:
      begin
        nxt_rd_data[BUSY_BIT] = (state_ff != SW_IDLE);
        nxt_rd_data[CNT_LSB +: CNT_W] = limit_ff;
      end
      default:
      begin
        nxt_rd_data = '0;
      end
    endcase
  end

  // Read data stands for one cycle and then returns to zero.
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      rd_data_ff <= '0;
    end
    else
    begin
      rd_data_ff <= rd_en ? nxt_rd_data : '0;
    end
  end

  // Every output leaves straight from a flip-flop.
  assign rd_data = rd_data_ff;
  assign main_clk_sel = main_clock_status_bit_ff;
  assign periph_clk_sel = periph_sel_ff;
  assign system_clock_stop_ctrl = sys_stop_ff;
  assign internal_osc_stop_ctrl = osc_stop_ff;
endmodule

// File: bench/clk_switch_asserts.sv
// Checker for the main clock switchover, bound to the top module.
`timescale 1ns/1ps
module clk_switch_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [clk_switch_pkg::ADDR_W-1:0] addr,
  input wire logic [clk_switch_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [clk_switch_pkg::DATA_W-1:0] rd_data,
  input wire logic int_osc_tick,
  input wire logic sys_clk_tick,
  input wire logic main_clk_sel,
  input wire logic periph_clk_sel,
  input wire logic system_clock_stop_ctrl,
  input wire logic internal_osc_stop_ctrl
);
  import clk_switch_pkg::*;
  logic sel_ff;
  logic ctl_rd;
  logic old_tick;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  assign ctl_rd = rd_en && addr == CTRL_OFF;
  assign old_tick = main_clk_sel ? sys_clk_tick : int_osc_tick;
  // Shadow of the last written select value.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sel_ff <= SEL_RST;
    else if (wr_en && addr == CTRL_OFF)
      sel_ff <= wr_data[SEL_BIT];
  end
  periph_follow_a: assert property (
    periph_clk_sel == main_clk_sel) else $error("periph sel differs");
  old_tick_a: assert property (
    $changed(main_clk_sel) |-> $past(old_tick) || $past(old_tick, 2))
    else $error("switch without old tick");
  not_instant_a: assert property (
    wr_en && addr == CTRL_OFF && wr_data[SEL_BIT] != sel_ff
    && sel_ff == main_clk_sel |=> $stable(main_clk_sel)[*2])
    else $error("switch too early");
  status_read_a: assert property (
    ctl_rd |=> rd_data[STATUS_BIT] == $past(main_clk_sel))
    else $error("status bit wrong");
  select_read_a: assert property (
    ctl_rd |=> rd_data[SEL_BIT] == $past(sel_ff))
    else $error("select bit wrong");
  lat_bound_a: assert property (
    main_clk_sel != sel_ff |-> ##[0:300] main_clk_sel == sel_ff)
    else $error("switch never done");
  sys_stop_a: assert property (
    $rose(system_clock_stop_ctrl) |-> !$past(main_clk_sel))
    else $error("system stop while on it");
  osc_stop_a: assert property (
    $rose(internal_osc_stop_ctrl) |-> $past(main_clk_sel))
    else $error("osc stop while on it");
  cover property ($rose(main_clk_sel));
  cover property ($fell(main_clk_sel));
  cover property ($rose(internal_osc_stop_ctrl));
endmodule
bind main_clock_switchover clk_switch_asserts chk (.*);

// File: bench/tb_top.sv
// Self-checking bench for the main clock switchover.
`timescale 1ns/1ps
module tb_top;
  import clk_switch_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic int_osc_tick = 1'b0;
  logic sys_clk_tick = 1'b0;
  logic main_clk_sel;
  logic periph_clk_sel;
  logic system_clock_stop_ctrl;
  logic internal_osc_stop_ctrl;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  main_clock_switchover dut (.*);
  always #2 clk = ~clk;
  // Old sources tick every second and every third cycle.
  always @(posedge clk)
  begin
    int_osc_tick <= (cycles % 2) == 0;
    sys_clk_tick <= (cycles % 3) == 0;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    check(rd_data, e);
  endtask
  task automatic reset_values();
    rdc(CTRL_OFF, 32'h0000_0000);
    rdc(FREQ_OFF, 32'h0000_0A08);
    rdc(STOP_OFF, 32'h0000_0001);
    wr(8'h10, 32'hFFFF_FFFF);
    rdc(8'h10, 32'h0000_0000);
  endtask
  // Sets both stop bits; only the one for the idle source may stick.
  task automatic stop_guard(input logic [DATA_W-1:0] e);
    wr(STOP_OFF, 32'h0000_0003);
    rdc(STOP_OFF, e);
    check(32'(internal_osc_stop_ctrl), 32'(e[1]));
    check(32'(system_clock_stop_ctrl), 32'(e[0]));
    wr(STOP_OFF, 32'h0000_0000);
  endtask
  task automatic switch_to(input logic to, input logic [15:0] freq,
    input logic [9:0] n);
    int w;
    wr(FREQ_OFF, {16'h0000, freq});
    wr(CTRL_OFF, 32'(to) << SEL_BIT);
    @(negedge clk);
    check(32'(main_clk_sel), 32'(!to));
    w = 0;
    while (main_clk_sel !== to && w < 400)
    begin
      @(negedge clk);
      w++;
    end
    check(32'(periph_clk_sel), 32'(to));
    rdc(CTRL_OFF, 32'(to) * 32'h0000_0030);
    rdc(STAT_OFF, {14'h0, n, 8'h00});
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    reset_values();
    wr(STOP_OFF, 32'h0000_0000);
    switch_to(1'b1, 16'h0A08, 10'h002);
    stop_guard(32'h0000_0002);
    switch_to(1'b0, 16'h0A08, 10'h003);
    stop_guard(32'h0000_0001);
    switch_to(1'b1, 16'h0408, 10'h003);
    switch_to(1'b0, 16'h0408, 10'h002);
    switch_to(1'b1, 16'h0409, 10'h004);
    close_out();
  end
endmodule
